/* src/rf_port_pkg.sv */
// constants, enums and carrier structs for the modem host serial port
// assumes a single 25 MHz system clock shared by every user of the package
package rf_port_pkg;

    localparam int CLK_HZ = 25_000_000;
    localparam int BAUD_W = 16;
    localparam int DEF_BAUD = 9600;
    localparam logic [BAUD_W-1:0] BAUD_DIV_DEF = BAUD_W'(CLK_HZ / DEF_BAUD);
    localparam int DATA_BITS = 8;
    localparam int FRAME_BITS = DATA_BITS + 2;
    localparam logic START_BIT = 1'h0;
    localparam logic STOP_BIT = 1'h1;
    localparam logic LINE_IDLE = 1'h1;

    // typical figures at 9600 baud, 32-byte packets, sync setting zero
    localparam real CHAN_INIT_TIME_MS = 35.0;
    localparam real TRANSMIT_LOW_TIME_MS = 16.8;
    localparam real RECEIVE_HIGH_TIME_MS = 25.6;
    localparam int CHAN_INIT_CYC = int'(CHAN_INIT_TIME_MS * CLK_HZ / 1000.0);
    localparam int TRANSMIT_LOW_CYC =
        int'(TRANSMIT_LOW_TIME_MS * CLK_HZ / 1000.0);
    localparam int RECEIVE_HIGH_CYC =
        int'(RECEIVE_HIGH_TIME_MS * CLK_HZ / 1000.0);

    // reset line: least low pulse seen as reboot, and own drive length
    localparam real RESET_MIN_US = 90.0;
    localparam real RESET_DRIVE_US = 100.0;
    localparam int RESET_MIN_CYC = int'($ceil(RESET_MIN_US * CLK_HZ / 1.0e6));
    localparam int RESET_DRIVE_CYC =
        int'($ceil(RESET_DRIVE_US * CLK_HZ / 1.0e6));

    localparam int TIME_W = 20;
    localparam int LEVEL_W = 11;
    localparam int DI_DEPTH_DEF = 1000;
    localparam int CTS_OFF_FREE = 65;
    localparam int CTS_ON_GAP = 34;

    typedef enum logic {FLOW_OUT_CTS, FLOW_OUT_RS485} flow_out_mode_e;
    typedef enum logic [1:0] {
        FLOW_IN_IGNORE,
        FLOW_IN_RTS,
        FLOW_IN_CMD
    } flow_in_mode_e;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_INIT, SEQ_SEND} seq_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_e;

    typedef struct packed {
        flow_out_mode_e flow_out_mode;
        flow_in_mode_e flow_in_pin_config;
        logic rx_ind_en;
        logic [BAUD_W-1:0] baud_div;
    } cfg_s;

    typedef struct packed {
        logic sleep;
        logic rx_active;
    } radio_s;

endpackage

/* src/serial_rx.sv */
// serial receiver: 8-N-1 characters from the host line, centre sampled
// assumes baud_div_in is stable while a character is in flight
`timescale 1ns/100ps
module serial_rx #(
    parameter int BAUD_W = rf_port_pkg::BAUD_W
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic line_in,
    input wire logic [BAUD_W-1:0] baud_div_in,
    output logic [7:0] byte_out,
    output logic valid_out,
    output logic frame_err_out
);

    if (BAUD_W < 2) begin : g_bad_width
        $error("serial_rx: BAUD_W too small");
    end

    typedef struct packed {
        logic [1:0] sync;
        rf_port_pkg::rx_e state;
        logic [BAUD_W-1:0] cnt;
        logic [2:0] idx;
        logic [7:0] shift;
        logic [7:0] byte_o;
        logic valid_o;
        logic ferr_o;
    } rx_s;

    rx_s st_reg;
    rx_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.sync = {st_reg.sync[0], line_in};
        st_next.valid_o = 1'h0;
        st_next.ferr_o = 1'h0;
        case (st_reg.state)
            rf_port_pkg::RX_IDLE: begin
                // idle line is high, so a low level is a start edge
                if (!st_reg.sync[1]) begin
                    st_next.state = rf_port_pkg::RX_START;
                    st_next.cnt = baud_div_in >> 1;
                end
            end
            rf_port_pkg::RX_START: begin
                if (st_reg.cnt == '0) begin
                    // a start bit gone high at mid-bit was a glitch
                    if (!st_reg.sync[1]) begin
                        st_next.state = rf_port_pkg::RX_DATA;
                        st_next.cnt = baud_div_in - 1'h1;
                        st_next.idx = '0;
                    end else begin
                        st_next.state = rf_port_pkg::RX_IDLE;
                    end
                end else begin
                    st_next.cnt = st_reg.cnt - 1'h1;
                end
            end
            rf_port_pkg::RX_DATA: begin
                if (st_reg.cnt == '0) begin
                    // lsb arrives first, so shift in from the top
                    st_next.shift = {st_reg.sync[1], st_reg.shift[7:1]};
                    st_next.cnt = baud_div_in - 1'h1;
                    st_next.idx = st_reg.idx + 1'h1;
                    if (st_reg.idx == 3'(rf_port_pkg::DATA_BITS - 1)) begin
                        st_next.state = rf_port_pkg::RX_STOP;
                    end
                end else begin
                    st_next.cnt = st_reg.cnt - 1'h1;
                end
            end
            rf_port_pkg::RX_STOP: begin
                if (st_reg.cnt == '0) begin
                    st_next.state = rf_port_pkg::RX_IDLE;
                    if (st_reg.sync[1]) begin
                        st_next.byte_o = st_reg.shift;
                        st_next.valid_o = 1'h1;
                    end else begin
                        st_next.ferr_o = 1'h1;
                    end
                end else begin
                    st_next.cnt = st_reg.cnt - 1'h1;
                end
            end
            default: begin
                st_next.state = rf_port_pkg::RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
            st_reg.sync <= 2'h3;
        end else begin
            st_reg <= st_next;
        end
    end

    assign byte_out = st_reg.byte_o;
    assign valid_out = st_reg.valid_o;
    assign frame_err_out = st_reg.ferr_o;

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_stop_accept: assert property (
        valid_out |-> $past(st_reg.state) == rf_port_pkg::RX_STOP
            && $past(st_reg.sync[1]) && !frame_err_out)
        else $error("character accepted without a high stop bit");
    a_stop_discard: assert property (
        (st_reg.state == rf_port_pkg::RX_STOP && st_reg.cnt == '0
            && !st_reg.sync[1]) |=> frame_err_out && !valid_out)
        else $error("low stop bit did not discard the character");
    c_rx_char: cover property (valid_out);

endmodule // serial_rx

/* src/modem_serial_port.sv */
// host serial port of the radio modem: transmitter toward the host,
// receiver instance, flow pins, status pins and the open-drain reset line
// assumes the packet engine, the DI buffer and sleep control sit outside
`timescale 1ns/100ps

module modem_serial_port #(
    parameter int CHAN_INIT_CYC = rf_port_pkg::CHAN_INIT_CYC,
    parameter int TRANSMIT_LOW_CYC = rf_port_pkg::TRANSMIT_LOW_CYC,
    parameter int RECEIVE_HIGH_CYC = rf_port_pkg::RECEIVE_HIGH_CYC,
    parameter int DI_DEPTH = rf_port_pkg::DI_DEPTH_DEF
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire rf_port_pkg::cfg_s cfg_in,
    input wire rf_port_pkg::radio_s radio_in,
    input wire logic [rf_port_pkg::LEVEL_W-1:0] di_free_in,
    input wire logic serial_in_pin_in,
    input wire logic flow_in_pin_in,
    input wire logic reset_line_in,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    output logic [7:0] rx_data_out,
    output logic rx_valid_out,
    output logic rx_frame_err_out,
    output logic serial_out_pin_out,
    output logic flow_out_pin_out,
    output logic on_sleep_out,
    output logic tx_pwr_out,
    output logic receive_indicator_out,
    output logic cmd_select_out,
    output logic packet_send_out,
    output logic reboot_out,
    output logic reset_line_out,
    output logic reset_line_oe_out
);

    localparam int TW = rf_port_pkg::TIME_W;
    localparam int LW = rf_port_pkg::LEVEL_W;
    localparam int FB = rf_port_pkg::FRAME_BITS;

    if (CHAN_INIT_CYC < 1 || CHAN_INIT_CYC >= 2 ** TW
        || TRANSMIT_LOW_CYC < 1 || TRANSMIT_LOW_CYC >= 2 ** TW
        || RECEIVE_HIGH_CYC < 1 || RECEIVE_HIGH_CYC >= 2 ** TW
        || DI_DEPTH <= rf_port_pkg::CTS_OFF_FREE + rf_port_pkg::CTS_ON_GAP
        || DI_DEPTH >= 2 ** LW) begin : g_bad_param
        $error("modem_serial_port: parameter out of range");
    end

    typedef struct packed {
        logic [1:0] rts_s;
        logic [1:0] rst_s;
        logic tx_busy;
        logic [FB-1:0] tx_shift;
        logic [3:0] tx_bits;
        logic [rf_port_pkg::BAUD_W-1:0] tx_cnt;
        logic tx_ready;
        logic ser_o;
        logic cts_off;
        logic flow_o;
        logic cmd_o;
        rf_port_pkg::seq_e seq;
        logic [TW-1:0] seq_cnt;
        logic send_o;
        logic on_o;
        logic txpwr_o;
        logic rx_act_d;
        logic [TW-1:0] rxi_cnt;
        logic rxi_o;
        logic [TW-1:0] rl_cnt;
        logic rl_armed;
        logic [TW-1:0] drv_cnt;
        logic drv_o;
        logic reboot_o;
    } top_s;

    top_s st_reg;
    top_s st_next;

    serial_rx #(
        .BAUD_W(rf_port_pkg::BAUD_W)
    ) u_rx (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .line_in(serial_in_pin_in),
        .baud_div_in(cfg_in.baud_div),
        .byte_out(rx_data_out),
        .valid_out(rx_valid_out),
        .frame_err_out(rx_frame_err_out)
    );

    always_comb begin
        logic rts_ok;
        logic pending;
        // request-to-send is active low; other modes never hold output
        rts_ok = (cfg_in.flow_in_pin_config != rf_port_pkg::FLOW_IN_RTS)
            || !st_reg.rts_s[1];
        pending = di_free_in < LW'(DI_DEPTH);
        st_next = st_reg;
        st_next.rts_s = {st_reg.rts_s[0], flow_in_pin_in};
        st_next.rst_s = {st_reg.rst_s[0], reset_line_in};
        st_next.reboot_o = 1'h0;

        if (st_reg.tx_busy) begin
            if (st_reg.tx_cnt == '0) begin
                st_next.tx_cnt = cfg_in.baud_div - 1'h1;
                st_next.tx_shift = {rf_port_pkg::LINE_IDLE,
                    st_reg.tx_shift[FB-1:1]};
                st_next.tx_bits = st_reg.tx_bits - 1'h1;
                if (st_reg.tx_bits == 4'h1) begin
                    st_next.tx_busy = 1'h0;
                end
            end else begin
                st_next.tx_cnt = st_reg.tx_cnt - 1'h1;
            end
        end else if (st_reg.tx_ready && tx_valid_in) begin
            st_next.tx_busy = 1'h1;
            st_next.tx_shift = {rf_port_pkg::STOP_BIT, tx_data_in,
                rf_port_pkg::START_BIT};
            st_next.tx_bits = 4'(FB);
            st_next.tx_cnt = cfg_in.baud_div - 1'h1;
        end
        st_next.ser_o = st_next.tx_busy ? st_next.tx_shift[0]
            : rf_port_pkg::LINE_IDLE;
        st_next.tx_ready = !st_next.tx_busy && rts_ok;

        // hysteresis keeps the pin from chattering near the threshold
        if (di_free_in <= LW'(rf_port_pkg::CTS_OFF_FREE)) begin
            st_next.cts_off = 1'h1;
        end else if (di_free_in >= LW'(rf_port_pkg::CTS_OFF_FREE
            + rf_port_pkg::CTS_ON_GAP)) begin
            st_next.cts_off = 1'h0;
        end
        if (cfg_in.flow_out_mode == rf_port_pkg::FLOW_OUT_RS485) begin
            st_next.flow_o = st_next.tx_busy;
        end else begin
            st_next.flow_o = st_next.cts_off;
        end
        st_next.cmd_o = (cfg_in.flow_in_pin_config
            == rf_port_pkg::FLOW_IN_CMD) && st_reg.rts_s[1];

        case (st_reg.seq)
            rf_port_pkg::SEQ_IDLE: begin
                if (pending && !radio_in.rx_active) begin
                    st_next.seq = rf_port_pkg::SEQ_INIT;
                    st_next.seq_cnt = TW'(CHAN_INIT_CYC - 1);
                end
            end
            rf_port_pkg::SEQ_INIT: begin
                if (st_reg.seq_cnt == '0) begin
                    st_next.seq = rf_port_pkg::SEQ_SEND;
                    st_next.seq_cnt = TW'(TRANSMIT_LOW_CYC - 1);
                end else begin
                    st_next.seq_cnt = st_reg.seq_cnt - 1'h1;
                end
            end
            rf_port_pkg::SEQ_SEND: begin
                // follow-on packets go out without a new initializer
                if (st_reg.seq_cnt != '0) begin
                    st_next.seq_cnt = st_reg.seq_cnt - 1'h1;
                end else if (pending && !radio_in.rx_active) begin
                    st_next.seq_cnt = TW'(TRANSMIT_LOW_CYC - 1);
                end else begin
                    st_next.seq = rf_port_pkg::SEQ_IDLE;
                end
            end
            default: begin
                st_next.seq = rf_port_pkg::SEQ_IDLE;
            end
        endcase
        st_next.send_o = st_next.seq == rf_port_pkg::SEQ_SEND;
        st_next.on_o = !radio_in.sleep;
        st_next.txpwr_o = !radio_in.sleep && !st_next.send_o;

        st_next.rx_act_d = radio_in.rx_active;
        if (radio_in.rx_active && !st_reg.rx_act_d) begin
            st_next.rxi_cnt = TW'(RECEIVE_HIGH_CYC - 1);
        end else if (st_reg.rxi_cnt != '0) begin
            st_next.rxi_cnt = st_reg.rxi_cnt - 1'h1;
        end
        st_next.rxi_o = cfg_in.rx_ind_en && (radio_in.rx_active
            || st_next.rxi_cnt != '0);

        // own drive is blanked so it cannot retrigger a reboot
        if (st_reg.drv_cnt != '0) begin
            st_next.drv_cnt = st_reg.drv_cnt - 1'h1;
            st_next.rl_cnt = '0;
            st_next.rl_armed = 1'h0;
        end else if (st_reg.rst_s[1]) begin
            st_next.rl_cnt = '0;
            st_next.rl_armed = 1'h1;
        end else if (st_reg.rl_armed) begin
            if (st_reg.rl_cnt == TW'(rf_port_pkg::RESET_MIN_CYC - 1)) begin
                st_next.reboot_o = 1'h1;
                st_next.drv_cnt = TW'(rf_port_pkg::RESET_DRIVE_CYC);
                st_next.rl_armed = 1'h0;
            end else begin
                st_next.rl_cnt = st_reg.rl_cnt + 1'h1;
            end
        end
        st_next.drv_o = st_next.drv_cnt != '0;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
            st_reg.rts_s <= 2'h3;
            st_reg.rst_s <= 2'h3;
            st_reg.ser_o <= rf_port_pkg::LINE_IDLE;
            st_reg.flow_o <= 1'h1;
            // power-up drive of the reset line
            st_reg.drv_cnt <= TW'(rf_port_pkg::RESET_DRIVE_CYC);
            st_reg.drv_o <= 1'h1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tx_ready_out = st_reg.tx_ready;
    assign serial_out_pin_out = st_reg.ser_o;
    assign flow_out_pin_out = st_reg.flow_o;
    assign on_sleep_out = st_reg.on_o;
    assign tx_pwr_out = st_reg.txpwr_o;
    assign receive_indicator_out = st_reg.rxi_o;
    assign cmd_select_out = st_reg.cmd_o;
    assign packet_send_out = st_reg.send_o;
    assign reboot_out = st_reg.reboot_o;
    // open drain: the line is only ever pulled low
    assign reset_line_out = 1'h0;
    assign reset_line_oe_out = st_reg.drv_o;

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_line_idle: assert property (
        !st_reg.tx_busy |-> serial_out_pin_out)
        else $error("output line not high while idle");
    a_start_stop: assert property (
        (tx_ready_out && tx_valid_in) |=> !serial_out_pin_out
            && st_reg.tx_bits == 4'(FB) && st_reg.tx_shift[FB-1])
        else $error("frame did not open with start and hold stop bit");
    a_rts_gate: assert property (
        (cfg_in.flow_in_pin_config == rf_port_pkg::FLOW_IN_RTS
            && st_reg.rts_s[1]) |=> !tx_ready_out)
        else $error("output offered while request-to-send deasserted");
    a_rts_ignored: assert property (
        (cfg_in.flow_in_pin_config == rf_port_pkg::FLOW_IN_IGNORE
            && !st_reg.tx_busy && !tx_valid_in) |=> tx_ready_out)
        else $error("request-to-send not ignored by default");
    a_cts_off: assert property (
        (cfg_in.flow_out_mode == rf_port_pkg::FLOW_OUT_CTS
            && di_free_in <= LW'(rf_port_pkg::CTS_OFF_FREE))
            |=> flow_out_pin_out)
        else $error("clear-to-send still low near full buffer");
    a_rs485_enable: assert property (
        (cfg_in.flow_out_mode == rf_port_pkg::FLOW_OUT_RS485)
            |=> flow_out_pin_out == st_reg.tx_busy)
        else $error("driver enable does not follow transmitter");
    a_sleep_pwr: assert property (
        !on_sleep_out |-> !tx_pwr_out)
        else $error("power status high while asleep");
    a_send_low: assert property (
        packet_send_out |-> !tx_pwr_out)
        else $error("transmit status not low during send");
    a_init_first: assert property (
        $rose(packet_send_out) |-> $past(st_reg.seq) == rf_port_pkg::SEQ_INIT)
        else $error("payload without channel initialization");
    a_no_send_rx: assert property (
        (st_reg.seq == rf_port_pkg::SEQ_IDLE && radio_in.rx_active)
            |=> !packet_send_out && st_reg.seq == rf_port_pkg::SEQ_IDLE)
        else $error("send started while receiving");
    a_rx_ind_off: assert property (
        !cfg_in.rx_ind_en |=> !receive_indicator_out)
        else $error("receive indicator high while disabled");
    a_cmd_select: assert property (
        cmd_select_out |-> $past(cfg_in.flow_in_pin_config)
            == rf_port_pkg::FLOW_IN_CMD)
        else $error("command select outside command mode");
    a_reboot_drive: assert property (
        reboot_out |-> reset_line_oe_out ##1 reset_line_oe_out)
        else $error("reboot did not drive the reset line");

    c_tx_frame: cover property ((tx_ready_out && tx_valid_in) ##1
        st_reg.tx_busy [*8]);
    c_send: cover property ($fell(packet_send_out));
    c_reboot: cover property (reboot_out);
    c_cts_cycle: cover property ($rose(flow_out_pin_out) ##[1:1000]
        $fell(flow_out_pin_out));

endmodule // modem_serial_port

/* bench/host_uart.sv */
// host microcontroller uart model: sends and samples 8-N-1 characters
// assumes tasks are called just after a rising edge of sys_clk_in
`timescale 1ns/100ps
module host_uart #(
    parameter int DIV = 16
) (
    input wire logic sys_clk_in,
    input wire logic line_in,
    output logic line_out
);
    initial line_out = 1'h1;
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'h0};
        for (int i = 0; i < 10; i++) begin
            line_out <= f[i];
            repeat (DIV) @(posedge sys_clk_in);
        end
        line_out <= 1'h1;
        repeat (DIV) @(posedge sys_clk_in);
    endtask
    // bounded hunt for the start bit, then mid-bit sampling
    task automatic recv(output logic [7:0] b, output logic ok);
        int n;
        ok = 1'h0;
        b = 8'h00;
        for (n = 0; n < 4000 && line_in !== 1'h0; n++)
            @(negedge sys_clk_in);
        if (line_in !== 1'h0) return;
        repeat (DIV / 2) @(negedge sys_clk_in);
        for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(negedge sys_clk_in);
            b[i] = line_in;
        end
        repeat (DIV) @(negedge sys_clk_in);
        ok = (line_in === 1'h1);
    endtask
endmodule // host_uart

/* bench/tb_top.sv */
// self-checking bench for the modem host serial port
// assumes short sim counts and a 16-clock bit time
`timescale 1ns/100ps
module tb_top;
    localparam int DIV = 16;
    logic sys_clk_in, rst_n_in, ext_rst_n, serial_in, flow_in, tx_valid;
    logic [7:0] tx_data, rx_data, b;
    logic [10:0] di_free;
    rf_port_pkg::cfg_s cfg;
    rf_port_pkg::radio_s radio;
    logic tx_ready, rx_valid, rx_ferr, ser_out, flow_out, on_sleep, tx_pwr;
    logic rx_ind, cmd_sel, pkt_send, reboot, rl_out, rl_oe, rl, ok;
    int n_mismatch = 0, checks = 0, n_ferr = 0, n;
    logic [7:0] got_q[$];
    // open-drain reset line with pull-up
    assign rl = (rl_oe ? rl_out : 1'h1) & ext_rst_n;
    modem_serial_port #(.CHAN_INIT_CYC(20), .TRANSMIT_LOW_CYC(10),
        .RECEIVE_HIGH_CYC(15)) i_dut (.sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in), .cfg_in(cfg), .radio_in(radio),
        .di_free_in(di_free), .serial_in_pin_in(serial_in),
        .flow_in_pin_in(flow_in), .reset_line_in(rl),
        .tx_data_in(tx_data), .tx_valid_in(tx_valid),
        .tx_ready_out(tx_ready), .rx_data_out(rx_data),
        .rx_valid_out(rx_valid), .rx_frame_err_out(rx_ferr),
        .serial_out_pin_out(ser_out), .flow_out_pin_out(flow_out),
        .on_sleep_out(on_sleep), .tx_pwr_out(tx_pwr),
        .receive_indicator_out(rx_ind), .cmd_select_out(cmd_sel),
        .packet_send_out(pkt_send), .reboot_out(reboot),
        .reset_line_out(rl_out), .reset_line_oe_out(rl_oe));
    host_uart #(.DIV(DIV)) i_host (.sys_clk_in(sys_clk_in),
        .line_in(ser_out), .line_out(serial_in));
    initial begin
        sys_clk_in = 1'h0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end
    always @(negedge sys_clk_in) begin
        if (rx_valid === 1'h1) got_q.push_back(rx_data);
        if (rx_ferr === 1'h1) n_ferr++;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic fail();
        n_mismatch++;
        close_out();
    endtask
    task automatic tick(input int c);
        repeat (c) @(negedge sys_clk_in);
    endtask
    task automatic put_byte(input logic [7:0] d);
        @(posedge sys_clk_in);
        tx_data <= d;
        tx_valid <= 1'h1;
        for (n = 0; n < 400 && tx_ready !== 1'h1; n++) tick(1);
        if (n == 400) fail();
        @(posedge sys_clk_in);
        tx_valid <= 1'h0;
    endtask
    task automatic get_byte(input logic [7:0] exp);
        i_host.recv(b, ok);
        if (ok !== 1'h1) fail();
        chk(b, exp);
    endtask
    task automatic t_rx();
        got_q.delete();
        n_ferr = 0;
        @(posedge sys_clk_in);
        i_host.send(8'h1F, 1'h1);
        i_host.send(8'hA5, 1'h1);
        i_host.send(8'h3C, 1'h0);
        tick(4);
        chk(16'(got_q.size()), 16'h0002);
        chk(got_q[0], 8'h1F);
        chk(got_q[1], 8'hA5);
        chk(16'(n_ferr), 16'h0001);
    endtask
    task automatic t_tx(input logic rs485, input logic [7:0] d);
        @(posedge sys_clk_in);
        cfg.flow_out_mode <= rs485 ? rf_port_pkg::FLOW_OUT_RS485
                                   : rf_port_pkg::FLOW_OUT_CTS;
        tick(2);
        put_byte(d);
        tick(2);
        if (rs485) chk(flow_out, 1'h1);
        get_byte(d);
        tick(DIV);
        if (rs485) chk(flow_out, 1'h0);
    endtask
    task automatic t_pins();
        @(posedge sys_clk_in);
        cfg.flow_in_pin_config <= rf_port_pkg::FLOW_IN_RTS;
        flow_in <= 1'h1;
        tick(5);
        chk(tx_ready, 1'h0);
        @(posedge sys_clk_in);
        tx_data <= 8'h96;
        tx_valid <= 1'h1;
        tick(3 * DIV);
        chk(ser_out, 1'h1);
        @(posedge sys_clk_in);
        flow_in <= 1'h0;
        put_byte(8'h96);
        get_byte(8'h96);
        @(posedge sys_clk_in);
        cfg.flow_in_pin_config <= rf_port_pkg::FLOW_IN_CMD;
        flow_in <= 1'h1;
        tick(5);
        chk(cmd_sel, 1'h1);
        @(posedge sys_clk_in);
        cfg.flow_in_pin_config <= rf_port_pkg::FLOW_IN_IGNORE;
        tick(5);
        chk({cmd_sel, tx_ready}, 2'h1);
        @(posedge sys_clk_in);
        flow_in <= 1'h0;
    endtask
    task automatic t_cts();
        logic [10:0] lv[5] = '{11'h0C8, 11'h042, 11'h041, 11'h062, 11'h063};
        logic ex[5] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
        @(posedge sys_clk_in);
        cfg.flow_out_mode <= rf_port_pkg::FLOW_OUT_CTS;
        for (int i = 0; i < 5; i++) begin
            @(posedge sys_clk_in);
            di_free <= lv[i];
            tick(3);
            chk(flow_out, ex[i]);
        end
        @(posedge sys_clk_in);
        di_free <= 11'h3E8;
        radio.sleep <= 1'h1;
        tick(3);
        chk({on_sleep, tx_pwr}, 2'h0);
        @(posedge sys_clk_in);
        radio.sleep <= 1'h0;
        // a packet begun by the level steps has to run out first
        tick(40);
        chk({on_sleep, tx_pwr}, 2'h3);
    endtask
    task automatic t_send();
        @(posedge sys_clk_in);
        di_free <= 11'h3E7;
        tick(10);
        chk(pkt_send, 1'h0);
        for (n = 0; n < 40 && pkt_send !== 1'h1; n++) tick(1);
        if (n == 40) fail();
        @(posedge sys_clk_in);
        di_free <= 11'h3E8;
        for (n = 0; n < 100 && tx_pwr === 1'h0; n++) tick(1);
        chk(16'(n), 16'h000A);
        @(posedge sys_clk_in);
        radio.rx_active <= 1'h1;
        di_free <= 11'h3E7;
        tick(60);
        chk({pkt_send, rx_ind}, 2'h1);
        @(posedge sys_clk_in);
        radio.rx_active <= 1'h0;
        di_free <= 11'h3E8;
        tick(3);
        chk(rx_ind, 1'h0);
        // indicator hold is timed from the start of reception
        @(posedge sys_clk_in);
        radio.rx_active <= 1'h1;
        @(posedge sys_clk_in);
        radio.rx_active <= 1'h0;
        tick(5);
        chk(rx_ind, 1'h1);
        tick(20);
        chk(rx_ind, 1'h0);
        @(posedge sys_clk_in);
        cfg.rx_ind_en <= 1'h0;
        radio.rx_active <= 1'h1;
        tick(3);
        chk(rx_ind, 1'h0);
        @(posedge sys_clk_in);
        radio.rx_active <= 1'h0;
        cfg.rx_ind_en <= 1'h1;
    endtask
    task automatic t_reset_line(input int len, input logic exp);
        logic seen;
        seen = 1'h0;
        for (n = 0; n < 3000 && rl_oe === 1'h1; n++) tick(1);
        chk(rl_oe, 1'h0);
        @(posedge sys_clk_in);
        ext_rst_n <= 1'h0;
        for (n = 0; n < len; n++) begin
            tick(1);
            if (reboot === 1'h1) seen = 1'h1;
        end
        chk({seen, rl_oe}, {exp, exp});
        @(posedge sys_clk_in);
        ext_rst_n <= 1'h1;
    endtask
    initial begin
        rst_n_in = 1'h0;
        ext_rst_n = 1'h1;
        flow_in = 1'h0;
        tx_valid = 1'h0;
        tx_data = 8'h00;
        di_free = 11'h3E8;
        radio = '0;
        cfg = '0;
        cfg.rx_ind_en = 1'h1;
        cfg.baud_div = 16'h0010;
        repeat (2) @(posedge sys_clk_in);
        rst_n_in <= 1'h1;
        tick(3);
        chk(rl_oe, 1'h1);
        t_rx();
        $display("host to module done");
        t_tx(1'h0, 8'hC3);
        t_tx(1'h1, 8'h5A);
        $display("module to host done");
        t_pins();
        $display("flow input pin done");
        t_cts();
        $display("flow output and status done");
        t_send();
        $display("send sequence done");
        t_reset_line(1000, 1'h0);
        t_reset_line(2400, 1'h1);
        $display("reset line done");
        close_out();
    end
endmodule // tb_top
